// *** hdl/hcc_regs.svh ***
// Purpose: register offsets, field positions, codes and reset values of the channel block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: definitions only
`ifndef HCC_REGS_SVH
`define HCC_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define HCC_OFF_CHSEL 8'h00
`define HCC_OFF_CFG 8'h04
`define HCC_OFF_FIRST_TX_DESC_ADDR 8'h08
`define HCC_OFF_CMD 8'h0C
`define HCC_OFF_STAT 8'h10

// ****************************************
// command word fields
// ****************************************
`define HCC_CMD_GRP 2:0
`define HCC_CMD_HOLD 3
`define HCC_CMD_NEWSZ 4
`define HCC_CMD_SIZE 10:5

// ****************************************
// configuration word fields
// ****************************************
`define HCC_CFG_MODE 1:0
`define HCC_CFG_CRC 2
`define HCC_CFG_CPT 3
`define HCC_CFG_INV 4
`define HCC_CFG_RATE 6:5
`define HCC_CFG_FA 7
`define HCC_CFG_IDLE_FILL_SELECT 8
`define HCC_CFG_NSF 9
`define HCC_CFG_TRANSPARENT_FILL_FLAG 31:16

// ****************************************
// codes and constants
// ****************************************
`define HCC_FILL_FLAG 16'h007E
`define HCC_FILL_ONES 16'hFFFF
`define HCC_FILL_ZERO 16'h0000
`define HCC_SIZE_MAX 6'h3F
`define HCC_SIZE_MIN 6'h01
`define HCC_ZINS_SHIFT 3
`define HCC_RST_WORD 32'h0000_0000
`endif

// *** hdl/hcc_pkg.sv ***
// Purpose: types shared by the channel command block
// Assumes: nothing
// Notes: codes written out
package hcc_pkg;
   typedef enum logic [2:0] {
      HCC_CMD_CLEAR = 3'h0,
      HCC_CMD_FAST_ABORT = 3'h1,
      HCC_CMD_OFF = 3'h2,
      HCC_CMD_ABORT = 3'h3,
      HCC_CMD_JUMP = 3'h4,
      HCC_CMD_INIT = 3'h5,
      HCC_CMD_RSVD6 = 3'h6,
      HCC_CMD_RSVD7 = 3'h7
   } hcc_cmd_t;
   typedef enum logic [1:0] {
      HCC_MODE_TMA = 2'h0,
      HCC_MODE_TMBR = 2'h1,
      HCC_MODE_V110 = 2'h2,
      HCC_MODE_HDLC = 2'h3
   } hcc_mode_t;
endpackage

// *** hdl/hcc_cfg_ram.sv ***
// Purpose: per-channel configuration store, one write and two registered read ports
// Assumes: single clock
// Notes: array has no reset, read registers do
`timescale 1ns/1ps
`include "hcc_regs.svh"
module hcc_cfg_ram #(
   parameter int AW = 5,
   parameter int DW = 32
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read ports
   input wire logic [AW-1:0] raddr_a,
   output logic [DW-1:0] rdata_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [DW-1:0] rdata_b
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_a <= DW'(`HCC_RST_WORD);
         rdata_b <= DW'(`HCC_RST_WORD);
      end else begin
         rdata_a <= mem[raddr_a];
         rdata_b <= mem[raddr_b];
      end
   end
endmodule

// *** hdl/hcc_chan_decode.sv ***
// Purpose: decodes one channel's configuration into fill code and formatter controls
// Assumes: cfg word laid out as in the register header
// Notes: purely combinational
`timescale 1ns/1ps
`include "hcc_regs.svh"
module hcc_chan_decode (
   // configuration in
   input wire logic [31:0] cfg,
   input wire logic hold_act,
   // decoded controls
   output logic [15:0] fill_char,
   output logic crc32_sel,
   output logic tmr_sel,
   output logic crc_gen_en,
   output logic rx_store_crc,
   output logic sf_suppress_off,
   output logic [2:0] d_repeat,
   output logic invert
);
   import hcc_pkg::*;
   hcc_mode_t mode;

   always_comb begin
      mode = hcc_mode_t'(cfg[`HCC_CFG_MODE]);
      fill_char = `HCC_FILL_ZERO;
      crc32_sel = 1'b0;
      tmr_sel = 1'b0;
      crc_gen_en = 1'b0;
      rx_store_crc = 1'b0;
      sf_suppress_off = 1'b0;
      d_repeat = 3'h0;
      invert = cfg[`HCC_CFG_INV];
      case (mode) // RULE_20
         HCC_MODE_HDLC: begin
            crc32_sel = cfg[`HCC_CFG_CRC]; // RULE_16
            crc_gen_en = !cfg[`HCC_CFG_CPT]; // RULE_15
            rx_store_crc = cfg[`HCC_CFG_CPT]; // RULE_15
            sf_suppress_off = cfg[`HCC_CFG_NSF] && cfg[`HCC_CFG_CPT]; // RULE_14
            fill_char = cfg[`HCC_CFG_IDLE_FILL_SELECT] ? `HCC_FILL_ONES : `HCC_FILL_FLAG; // RULE_07 RULE_21
         end
         HCC_MODE_V110: begin
            case (cfg[`HCC_CFG_RATE]) // RULE_17
               2'h0: d_repeat = 3'h7;
               2'h1: d_repeat = 3'h3;
               2'h2: d_repeat = 3'h1;
               default: d_repeat = 3'h0;
            endcase
            fill_char = `HCC_FILL_ZERO; // RULE_07
         end
         HCC_MODE_TMBR: begin
            tmr_sel = cfg[`HCC_CFG_CRC]; // RULE_16
            fill_char = `HCC_FILL_ZERO; // RULE_07
         end
         default: begin
            // flag code only in this mode, ones otherwise
            fill_char = cfg[`HCC_CFG_FA] ? cfg[`HCC_CFG_TRANSPARENT_FILL_FLAG] : `HCC_FILL_ONES; // RULE_13 RULE_19
         end
      endcase
      if (hold_act && mode == HCC_MODE_HDLC && cfg[`HCC_CFG_IDLE_FILL_SELECT]) begin
         fill_char = `HCC_FILL_ONES; // RULE_07
      end
   end
endmodule

// *** hdl/hcc_top.sv ***
// Purpose: transmit command interpreter and channel configuration for a 32-channel controller
// Assumes: AHB-Lite slave, zero wait states; DMA and formatter on the same clock
// Notes: command and configuration act on the channel in the select register
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "hcc_regs.svh"

// Behaviour
// RULE_01: jump clears off/abort, branches after descriptor
// RULE_02: jump keeps open frame in framed modes
// RULE_03: no transmit until initialization command
// RULE_04: initialization branches now, discards buffer
// RULE_05: buffer size only taken with flag
// RULE_06: hold finishes frame, V.110 zero abort
// RULE_07: hold sends mode-specific fill characters
// RULE_08: active hold stops buffer reads, polling
// RULE_09: software holds abort before transmit off
// RULE_10: software changes config only when shut
// RULE_11: first V.110 descriptor carries E,S,X
// RULE_12: software repeats hold and condition code
// RULE_13: fill flag used only in transparent_a
// RULE_14: no short frame suppression in HDLC; code turns suppression off only when NSF and CPT are both set
// RULE_15: CRC pass-through stores, suppresses generation
// RULE_16: CRC bit selects polynomial or sub-mode
// RULE_17: rate field sets D-bit repetitions
// RULE_18: flag adjust shortens fill by insertions
// RULE_19: flag filtering sends flag, else ones
// RULE_20: mode field selects transmission mode
// RULE_21: idle fill select picks flags or ones
// RULE_22: descriptor address used only by branches
// RULE_23: off resets formatter, tristates slots
// RULE_24: abort sends pattern, stops buffer reads
// RULE_25: off/abort state per channel, on commands
module hcc_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // dma command side
   output logic dma_cmd_valid,
   output logic [4:0] dma_cmd_ch,
   output logic dma_branch_now,
   output logic dma_branch_after,
   output logic dma_open_frame,
   output logic dma_tb_discard,
   output logic [31:0] dma_desc_addr,
   output logic dma_size_load,
   output logic [5:0] dma_size,
   // formatter command side
   output logic fmt_reset,
   output logic fmt_abort,
   output logic fmt_v110_abort,
   output logic [4:0] fmt_cmd_ch,
   input wire logic fmt_frame_done,
   input wire logic [4:0] fmt_done_ch,
   // per-channel enables
   output logic [31:0] slot_tristate,
   output logic [31:0] tb_read_en,
   output logic [31:0] desc_poll_en,
   // formatter configuration lookup
   input wire logic [4:0] fmt_query_ch,
   input wire logic [7:0] fill_count,
   input wire logic [10:0] zero_ins,
   output logic [15:0] fill_char,
   output logic [7:0] fill_adj,
   output logic crc32_sel,
   output logic tmr_sel,
   output logic crc_gen_en,
   output logic rx_store_crc,
   output logic sf_suppress_off,
   output logic [2:0] d_repeat,
   output logic invert
);
   import hcc_pkg::*;

   // ****************************************
   // bus slave
   // ****************************************
   logic wr_q, rd_q;
   logic [7:0] addr_q;
   logic [4:0] chsel_q;
   logic [31:0] first_tx_desc_addr_q;
   logic [31:0] cfg_a, cfg_b;
   logic [31:0] rd_d;
   logic cmd_we, cfg_we, cfg_byp_q;
   logic [31:0] cfg_wd_q;
   hcc_cmd_t kind;
   hcc_mode_t mode_a;
   logic [31:0] off_q, abort_q, init_q, hold_q, hact_q;

   assign cmd_we = wr_q && addr_q == `HCC_OFF_CMD;
   assign cfg_we = wr_q && addr_q == `HCC_OFF_CFG;
   assign kind = hcc_cmd_t'(hwdata[`HCC_CMD_GRP]);
   assign mode_a = hcc_mode_t'(cfg_a[`HCC_CFG_MODE]);

   always_comb begin
      case (haddr[7:0])
         `HCC_OFF_CHSEL: rd_d = {27'h0, chsel_q};
         `HCC_OFF_CFG: rd_d = cfg_we ? hwdata : (cfg_byp_q ? cfg_wd_q : cfg_a);
         `HCC_OFF_FIRST_TX_DESC_ADDR: rd_d = first_tx_desc_addr_q;
         `HCC_OFF_STAT: rd_d = {27'h0, hact_q[chsel_q], hold_q[chsel_q],
            abort_q[chsel_q], off_q[chsel_q], init_q[chsel_q]};
         default: rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
         cfg_byp_q <= 1'b0;
         cfg_wd_q <= `HCC_RST_WORD;
         hrdata <= `HCC_RST_WORD;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_q <= hsel && htrans[1] && hready && hwrite;
         rd_q <= hsel && htrans[1] && hready && !hwrite;
         // store read port lags a write by one cycle
         cfg_byp_q <= cfg_we;
         if (cfg_we) begin
            cfg_wd_q <= hwdata;
         end
         if (hsel && htrans[1] && hready) begin
            addr_q <= haddr[7:0];
            if (!hwrite) begin
               hrdata <= rd_d;
            end
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chsel_q <= 5'h00;
         first_tx_desc_addr_q <= `HCC_RST_WORD;
      end else if (wr_q) begin
         if (addr_q == `HCC_OFF_CHSEL) begin
            chsel_q <= hwdata[4:0];
         end
         if (addr_q == `HCC_OFF_FIRST_TX_DESC_ADDR) begin
            first_tx_desc_addr_q <= hwdata;
         end
      end
   end

   // ****************************************
   // configuration store
   // ****************************************
   hcc_cfg_ram #(.AW(5), .DW(32)) u_ram (
      .hclk(hclk),
      .hresetn(hresetn),
      .we(cfg_we),
      .waddr(chsel_q),
      .wdata(hwdata),
      .raddr_a(chsel_q),
      .rdata_a(cfg_a),
      .raddr_b(fmt_query_ch),
      .rdata_b(cfg_b)
   );

   // ****************************************
   // per-channel command state
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         off_q <= 32'h0;
         abort_q <= 32'h0;
         init_q <= 32'h0;
         hold_q <= 32'h0;
      end else if (cmd_we) begin
         hold_q[chsel_q] <= hwdata[`HCC_CMD_HOLD];
         case (kind) // RULE_25
            HCC_CMD_CLEAR: begin
               if (init_q[chsel_q]) begin
                  off_q[chsel_q] <= 1'b0;
                  abort_q[chsel_q] <= 1'b0;
               end
            end
            HCC_CMD_FAST_ABORT, HCC_CMD_JUMP: begin
               off_q[chsel_q] <= 1'b0; // RULE_01
               abort_q[chsel_q] <= 1'b0;
            end
            HCC_CMD_OFF: begin
               off_q[chsel_q] <= 1'b1; // RULE_23
               abort_q[chsel_q] <= 1'b0;
            end
            HCC_CMD_ABORT: begin
               abort_q[chsel_q] <= 1'b1; // RULE_24
            end
            HCC_CMD_INIT: begin
               init_q[chsel_q] <= 1'b1; // RULE_03
               off_q[chsel_q] <= 1'b0;
               abort_q[chsel_q] <= 1'b0;
            end
            default: begin
               off_q[chsel_q] <= off_q[chsel_q];
            end
         endcase
      end
   end

   // hold becomes active at the end of the current frame, or at once when the channel is uninitialized or off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hact_q <= 32'h0;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (!hold_q[i]) begin
               hact_q[i] <= 1'b0;
            end else if (fmt_frame_done && fmt_done_ch == 5'(i)) begin
               hact_q[i] <= 1'b1; // RULE_06
            end else if (!init_q[i] || off_q[i]) begin
               hact_q[i] <= 1'b1;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_en
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               slot_tristate[g] <= 1'b1;
               tb_read_en[g] <= 1'b0;
               desc_poll_en[g] <= 1'b0;
            end else begin
               slot_tristate[g] <= off_q[g] || !init_q[g]; // RULE_23
               tb_read_en[g] <= init_q[g] && !off_q[g] && !abort_q[g] && !hact_q[g]; // RULE_03 RULE_08 RULE_24
               desc_poll_en[g] <= init_q[g] && !off_q[g] && !hact_q[g]; // RULE_08
            end
         end
      end
   endgenerate

   // ****************************************
   // command pulses
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_cmd_valid <= 1'b0;
         dma_cmd_ch <= 5'h00;
         dma_branch_now <= 1'b0;
         dma_branch_after <= 1'b0;
         dma_open_frame <= 1'b0;
         dma_tb_discard <= 1'b0;
         dma_desc_addr <= `HCC_RST_WORD;
         dma_size_load <= 1'b0;
         dma_size <= 6'h00;
      end else begin
         dma_cmd_valid <= cmd_we;
         dma_branch_now <= cmd_we && (kind == HCC_CMD_INIT || kind == HCC_CMD_FAST_ABORT); // RULE_04
         dma_branch_after <= cmd_we && kind == HCC_CMD_JUMP; // RULE_01
         dma_open_frame <= cmd_we && kind == HCC_CMD_JUMP &&
            (mode_a == HCC_MODE_HDLC || mode_a == HCC_MODE_TMBR); // RULE_02
         dma_tb_discard <= cmd_we && kind == HCC_CMD_INIT; // RULE_04
         dma_size_load <= cmd_we && hwdata[`HCC_CMD_NEWSZ] &&
            hwdata[`HCC_CMD_SIZE] >= `HCC_SIZE_MIN && hwdata[`HCC_CMD_SIZE] <= `HCC_SIZE_MAX; // RULE_05
         if (cmd_we) begin
            dma_cmd_ch <= chsel_q;
            dma_size <= hwdata[`HCC_CMD_SIZE];
            if (kind == HCC_CMD_INIT || kind == HCC_CMD_FAST_ABORT || kind == HCC_CMD_JUMP) begin
               dma_desc_addr <= first_tx_desc_addr_q; // RULE_22
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fmt_reset <= 1'b0;
         fmt_abort <= 1'b0;
         fmt_v110_abort <= 1'b0;
         fmt_cmd_ch <= 5'h00;
      end else begin
         fmt_reset <= cmd_we && (kind == HCC_CMD_OFF ||
            (kind == HCC_CMD_INIT && !init_q[chsel_q])); // RULE_23 RULE_03
         fmt_abort <= cmd_we && kind == HCC_CMD_ABORT; // RULE_24
         fmt_v110_abort <= cmd_we && hwdata[`HCC_CMD_HOLD] && !hold_q[chsel_q] &&
            mode_a == HCC_MODE_V110; // RULE_06
         if (cmd_we) begin
            fmt_cmd_ch <= chsel_q;
         end
      end
   end

   // ****************************************
   // formatter configuration lookup
   // ****************************************
   logic [4:0] qch_q;
   logic [15:0] fill_d;
   logic c32_d, tmr_d, gen_d, st_d, sf_d, inv_d;
   logic [2:0] rep_d;
   logic [7:0] cut_d;

   hcc_chan_decode u_dec (
      .cfg(cfg_b),
      .hold_act(hact_q[qch_q]),
      .fill_char(fill_d),
      .crc32_sel(c32_d),
      .tmr_sel(tmr_d),
      .crc_gen_en(gen_d),
      .rx_store_crc(st_d),
      .sf_suppress_off(sf_d),
      .d_repeat(rep_d),
      .invert(inv_d)
   );

   assign cut_d = zero_ins[10:`HCC_ZINS_SHIFT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qch_q <= 5'h00;
         fill_char <= `HCC_FILL_ZERO;
         fill_adj <= 8'h00;
         crc32_sel <= 1'b0;
         tmr_sel <= 1'b0;
         crc_gen_en <= 1'b0;
         rx_store_crc <= 1'b0;
         sf_suppress_off <= 1'b0;
         d_repeat <= 3'h0;
         invert <= 1'b0;
      end else begin
         qch_q <= fmt_query_ch;
         fill_char <= fill_d; // RULE_07 RULE_19
         crc32_sel <= c32_d;
         tmr_sel <= tmr_d;
         crc_gen_en <= gen_d;
         rx_store_crc <= st_d;
         sf_suppress_off <= sf_d;
         d_repeat <= rep_d;
         invert <= inv_d;
         if (cfg_b[`HCC_CFG_FA] && cfg_b[`HCC_CFG_MODE] == HCC_MODE_HDLC) begin
            fill_adj <= (fill_count > cut_d) ? fill_count - cut_d : 8'h00; // RULE_18
         end else begin
            fill_adj <= fill_count;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_off_tristate: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_23
      cmd_we && kind == HCC_CMD_OFF |=> fmt_reset ##1 slot_tristate[fmt_cmd_ch])
      else $error("off did not reset formatter and tristate slots");
   a_jump_after: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
      cmd_we && kind == HCC_CMD_JUMP |=> dma_branch_after && !dma_branch_now && !dma_tb_discard)
      else $error("jump did not branch after the descriptor");
   a_init_discard: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
      cmd_we && kind == HCC_CMD_INIT |=> dma_branch_now && dma_tb_discard)
      else $error("init did not branch and discard buffer");
   a_addr_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_22
      cmd_we && (kind == HCC_CMD_CLEAR || kind == HCC_CMD_OFF || kind == HCC_CMD_ABORT)
      |=> $stable(dma_desc_addr))
      else $error("descriptor address taken by a non-branch command");
   a_size_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
      cmd_we && !hwdata[`HCC_CMD_NEWSZ] |=> !dma_size_load)
      else $error("buffer size loaded without flag");
   a_abort_stops: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_24
      cmd_we && kind == HCC_CMD_ABORT |=> fmt_abort ##1 !tb_read_en[fmt_cmd_ch])
      else $error("abort left buffer reads enabled");
   a_uninit_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
      !init_q[chsel_q] && !cmd_we |=> !tb_read_en[$past(chsel_q)])
      else $error("buffer read on an uninitialized channel");
   a_v110_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
      cmd_we && hwdata[`HCC_CMD_HOLD] && !hold_q[chsel_q] && mode_a == HCC_MODE_V110
      |=> fmt_v110_abort)
      else $error("hold in V.110 mode gave no zero abort");
   a_hold_stops: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
      hact_q[chsel_q] && !cmd_we |=> !desc_poll_en[$past(chsel_q)] && !tb_read_en[$past(chsel_q)])
      else $error("polling or buffer reads during active hold");
endmodule

// *** testbench/hcc_fmt_model.sv ***
// Purpose: formatter stand-in on the far side, reports frame completion per channel
// Assumes: one clock shared with the command block
// Notes: channel lines carry a changing pattern while no completion is reported
`timescale 1ns/1ps
module hcc_fmt_model #(
   parameter int DELAY = 3
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // request from the bench
   input wire logic finish,
   input wire logic [4:0] ch,
   // completion towards the block
   output logic fmt_frame_done,
   output logic [4:0] fmt_done_ch
);
   int cnt;
   logic [4:0] ch_q;

   // frame ends a few cycles after the request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         ch_q <= 5'h00;
         fmt_frame_done <= 1'b0;
         fmt_done_ch <= 5'h15;
      end else begin
         fmt_frame_done <= 1'b0;
         fmt_done_ch <= ~fmt_done_ch;
         if (finish) begin
            cnt <= DELAY;
            ch_q <= ch;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end else if (cnt == 1) begin
            cnt <= 0;
            fmt_frame_done <= 1'b1;
            fmt_done_ch <= ch_q;
         end
      end
   end
endmodule

// *** testbench/hcc_top_tb.sv ***
// Purpose: self-checking bench for the channel command block
// Assumes: zero-wait AHB-Lite slave, formatter model on the far side
// Notes: registers reached only through the bus tasks
`timescale 1ns/1ps
`include "hcc_regs.svh"
module hcc_top_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [4:0] fmt_query_ch = 5'h03;
   logic fin = 1'b0;
   logic hready, hreadyout, hresp, dma_cmd_valid, dma_branch_now, dma_branch_after;
   logic dma_open_frame, dma_tb_discard, dma_size_load, fmt_reset, fmt_abort;
   logic fmt_v110_abort, fmt_frame_done, crc32_sel, tmr_sel, crc_gen_en;
   logic rx_store_crc, sf_suppress_off, invert;
   logic [31:0] hrdata, dma_desc_addr, slot_tristate, tb_read_en, desc_poll_en;
   logic [31:0] vcnt = 32'h0;
   logic [4:0] dma_cmd_ch, fmt_cmd_ch, fmt_done_ch;
   logic [5:0] dma_size;
   logic [15:0] fill_char;
   logic [7:0] fill_adj;
   logic [7:0] seen = 8'h00;
   logic [2:0] d_repeat;
   logic [31:0] c;
   int err_total = 0;
   int compares = 0;
   logic [31:0] cfgs [10] = '{32'h2, 32'h22, 32'h42, 32'h62, 32'h11, 32'h5,
      32'hA55A_0080, 32'h0, 32'h30B, 32'h87};
   logic [15:0] fills [10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'hA55A, 16'hFFFF, 16'hFFFF, 16'h007E};
   logic [2:0] reps [4] = '{3'h7, 3'h3, 3'h1, 3'h0};

   assign hready = hreadyout;
   always #50 hclk = ~hclk;

   hcc_top hcc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dma_cmd_valid(dma_cmd_valid),
      .dma_cmd_ch(dma_cmd_ch), .dma_branch_now(dma_branch_now),
      .dma_branch_after(dma_branch_after), .dma_open_frame(dma_open_frame),
      .dma_tb_discard(dma_tb_discard), .dma_desc_addr(dma_desc_addr),
      .dma_size_load(dma_size_load), .dma_size(dma_size), .fmt_reset(fmt_reset),
      .fmt_abort(fmt_abort), .fmt_v110_abort(fmt_v110_abort), .fmt_cmd_ch(fmt_cmd_ch),
      .fmt_frame_done(fmt_frame_done), .fmt_done_ch(fmt_done_ch),
      .slot_tristate(slot_tristate), .tb_read_en(tb_read_en), .desc_poll_en(desc_poll_en),
      .fmt_query_ch(fmt_query_ch), .fill_count(8'h0A), .zero_ins(11'h018),
      .fill_char(fill_char), .fill_adj(fill_adj), .crc32_sel(crc32_sel), .tmr_sel(tmr_sel),
      .crc_gen_en(crc_gen_en), .rx_store_crc(rx_store_crc),
      .sf_suppress_off(sf_suppress_off), .d_repeat(d_repeat), .invert(invert));

   hcc_fmt_model hcc_fmt_model_i (.hclk(hclk), .hresetn(hresetn), .finish(fin),
      .ch(5'h03), .fmt_frame_done(fmt_frame_done), .fmt_done_ch(fmt_done_ch));

   // ****************************************
   // pulse monitor and tasks
   // ****************************************
   always @(posedge hclk) begin
      seen = seen | {dma_branch_now, dma_branch_after, dma_open_frame, dma_tb_discard,
         dma_size_load, fmt_reset, fmt_abort, fmt_v110_abort};
      vcnt = vcnt + {31'h0, dma_cmd_valid};
   end

   task automatic end_of_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 64) begin
            err_total++;
            $display("Error at %0t: bus wait ran out", $time);
            end_of_test();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask

   task automatic cmd(input logic [31:0] w, input logic [7:0] e);
      seen = 8'h00;
      vcnt = 32'h0;
      wr(`HCC_OFF_CMD, w);
      repeat (4) @(posedge hclk);
      chk(32'(seen), 32'(e));
      chk(vcnt, 32'h1);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(32'({hreadyout, hresp}), 32'h2);
      chk(slot_tristate, 32'hFFFF_FFFF);
      chk(tb_read_en | desc_poll_en, 32'h0);
      wr(`HCC_OFF_CHSEL, 32'h3);
      @(posedge hclk);
      rdc(`HCC_OFF_STAT, 32'h0);
      wr(8'h40, 32'hFFFF_FFFF);
      rdc(8'h40, 32'h0);
      for (int i = 0; i < 10; i++) begin
         c = cfgs[i];
         wr(`HCC_OFF_CFG, c);
         repeat (3) @(posedge hclk);
         chk(32'(fill_char), 32'(fills[i]));
         chk(32'(invert), 32'(c[4]));
         if (c[1:0] == 2'h3) chk(32'({crc32_sel, crc_gen_en, rx_store_crc, sf_suppress_off}),
            32'({c[2], ~c[3], c[3], c[9]}));
         if (c[1:0] == 2'h1) chk(32'(tmr_sel), 32'(c[2]));
         if (c[1:0] == 2'h2) chk(32'(d_repeat), 32'(reps[c[6:5]]));
         if (c[7] && c[1:0] == 2'h3) chk(32'(fill_adj), 32'h7);
         else chk(32'(fill_adj), 32'h0A);
      end
      wr(`HCC_OFF_FIRST_TX_DESC_ADDR, 32'h1000_0040);
      cmd(32'h0, 8'h00);
      rdc(`HCC_OFF_STAT, 32'h0);
      cmd(32'h215, 8'h9C);
      chk(dma_desc_addr, 32'h1000_0040);
      chk({dma_size, dma_cmd_ch, fmt_cmd_ch}, 32'h4063);
      chk(32'({tb_read_en[3], desc_poll_en[3], slot_tristate[3]}), 32'h6);
      wr(`HCC_OFF_FIRST_TX_DESC_ADDR, 32'h1000_0080);
      cmd(32'h7F5, 8'h98);
      chk(dma_desc_addr, 32'h1000_0080);
      wr(`HCC_OFF_FIRST_TX_DESC_ADDR, 32'h2000_0000);
      cmd(32'h3, 8'h02);
      chk(32'(tb_read_en[3]), 32'h0);
      rdc(`HCC_OFF_STAT, 32'h5);
      cmd(32'h2, 8'h04);
      chk(dma_desc_addr, 32'h1000_0080);
      chk(32'({tb_read_en[3], slot_tristate[3]}), 32'h1);
      rdc(`HCC_OFF_STAT, 32'h3);
      cmd(32'h4, 8'h60);
      chk(dma_desc_addr, 32'h2000_0000);
      rdc(`HCC_OFF_STAT, 32'h1);
      cmd(32'h8, 8'h00);
      rdc(`HCC_OFF_STAT, 32'h9);
      fin <= 1'b1;
      @(posedge hclk);
      fin <= 1'b0;
      repeat (8) @(posedge hclk);
      rdc(`HCC_OFF_STAT, 32'h19);
      chk(32'({tb_read_en[3], desc_poll_en[3]}), 32'h0);
      cmd(32'h0, 8'h00);
      rdc(`HCC_OFF_STAT, 32'h1);
      wr(`HCC_OFF_CHSEL, 32'h5);
      @(posedge hclk);
      wr(`HCC_OFF_CFG, 32'h2);
      rdc(`HCC_OFF_CFG, 32'h2);
      cmd(32'hA, 8'h05);
      chk(32'(fmt_cmd_ch), 32'h5);
      rdc(`HCC_OFF_STAT, 32'h1A);
      cmd(32'hC, 8'h40);
      cmd(32'h5, 8'h94);
      chk(dma_desc_addr, 32'h2000_0000);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      $display("Error at %0t: run limit reached", $time);
      end_of_test();
   end
endmodule
